/* File: design/spg_pkg.sv */
// Purpose: shared constants for the serial port general configuration block
// Assumes: 7-bit register addresses, 8-bit register data
// Notes:   frame layout counts are in serial clock bits

package spg_pkg;

    // register addresses
    localparam int                 ADDR_W         = 7;
    localparam int                 DATA_W         = 8;
    localparam logic [ADDR_W-1:0]  ADDR_GENERAL   = 7'h00;
    localparam logic [ADDR_W-1:0]  ADDR_ADC_A1_LO = 7'h1C;
    localparam logic [ADDR_W-1:0]  ADDR_ADC_A1_HI = 7'h1D;
    localparam logic [ADDR_W-1:0]  ADDR_ADC_B_LO  = 7'h1E;
    localparam logic [ADDR_W-1:0]  ADDR_ADC_B_HI  = 7'h1F;

    // plain read/write auxiliary registers, in port order
    localparam int                 AUX_RW_N       = 7;
    localparam logic [ADDR_W-1:0]  AUX_RW_ADDR [AUX_RW_N] = '{
        7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h28, 7'h29
    };

    // general register fields, and the read/write bit of the instruction byte
    localparam int                 BIT_SHARED_LINE = 7;
    localparam int                 BIT_LSB_FIRST   = 6;
    localparam int                 BIT_SOFT_RESET  = 5;
    localparam int                 BIT_RW          = 7;

    // values after reset
    localparam logic [DATA_W-1:0]  RST_GENERAL    = 8'h00;
    localparam logic [DATA_W-1:0]  RST_AUX        = 8'h00;

    // auxiliary converter result width
    localparam int                 ADC_W          = 10;

    // frame layout, counted in serial clock bits
    localparam int                 CNT_W          = 6;
    localparam logic [CNT_W-1:0]   CNT_MAX        = 6'h3F;
    localparam logic [CNT_W-1:0]   CNT_INSTR_LAST = 6'h07;
    localparam logic [CNT_W-1:0]   CNT_WR_LAST    = 6'h0F;
    localparam logic [CNT_W-1:0]   CNT_RD_FIRST   = 6'h17;
    localparam logic [CNT_W-1:0]   CNT_RD_LAST    = 6'h1E;

    // bit order swap within one byte
    function automatic logic [DATA_W-1:0] spg_rev8(
        input logic [DATA_W-1:0] v
    );
        logic [DATA_W-1:0] r;
        r = '0;
        for (int k = 0; k < DATA_W; k++) begin
            r[k] = v[DATA_W-1-k];
        end
        return r;
    endfunction

endpackage

/* File: design/spg_serial_port.sv */
// Purpose: serial control port with its general configuration register
// Assumes: frame ends when chip select rises; serial clock idles outside
//          frames; host samples device output on the rising serial edge
// Notes:   write frame 16 bits, read frame 8 + 16 wait + 8 data bits

`timescale 1ns/1ns
`default_nettype none

module spg_serial_port (
    // core clock and reset
    input  wire logic                             i_core_clk,
    input  wire logic                             i_rst_b,
    // serial link
    input  wire logic                             i_spi_sclk,
    input  wire logic                             i_spi_cs_b,
    input  wire logic                             i_spi_sdio,
    output var  logic                             o_spi_sdio,
    output var  logic                             o_spi_sdio_oe,
    output var  logic                             o_serial_data_output_pin,
    output var  logic                             o_serial_data_output_pin_oe,
    // auxiliary converter results
    input  wire logic [spg_pkg::ADC_W-1:0]        i_aux_adc_a1,
    input  wire logic [spg_pkg::ADC_W-1:0]        i_aux_adc_b,
    // configuration outputs
    output var  logic                             o_shared_data_line_select,
    output var  logic                             o_lsb_first,
    output var  logic                             o_pll_relock,
    output var  logic [spg_pkg::AUX_RW_N*8-1:0]   o_aux_regs
);
    import spg_pkg::*;

    // ------------------------------------------------------------------
    // serial clock domain
    // ------------------------------------------------------------------
    logic [CNT_W-1:0]     cnt_q;
    logic [CNT_W-1:0]     cnt_d;
    logic [15:0]          sh_q;
    logic [DATA_W-1:0]    instr_q;
    logic [15:0]          word_q;
    logic                 wr_ok_q;
    logic                 rd_go_q;
    logic                 out_q;
    logic                 sdio_oe_q;
    logic                 sdo_oe_q;
    logic                 dir_s1_q;
    logic                 dir_s2_q;
    logic                 lsb_s1_q;
    logic                 lsb_s2_q;

    // ------------------------------------------------------------------
    // core domain
    // ------------------------------------------------------------------
    logic                 cs_s1_q;
    logic                 cs_s2_q;
    logic                 cs_s3_q;
    logic                 go_s1_q;
    logic                 go_s2_q;
    logic                 go_s3_q;
    logic                 dir_q;
    logic                 lsb_q;
    logic                 relock_q;
    logic [DATA_W-1:0]    rdata_q;
    logic [DATA_W-1:0]    rdata_d;
    logic [DATA_W-1:0]    aux_q [AUX_RW_N];

    // serial side decode
    wire                  rw_raw;
    wire                  at_instr_last;
    wire                  at_wr_last;
    wire                  at_rd_first;
    wire                  out_win;
    wire  [2:0]           out_idx;

    // core side decode
    wire                  frame_end;
    wire                  rd_start;
    wire  [DATA_W-1:0]    wr_instr;
    wire  [DATA_W-1:0]    wr_data;
    wire  [DATA_W-1:0]    rd_instr;
    wire                  wr_fire;
    wire                  wr_general;
    wire                  soft_rst;
    wire                  cfg_rst;
    wire  [DATA_W-1:0]    rd_val;
    wire  [DATA_W-1:0]    gen_val;
    logic [DATA_W-1:0]    aux_val;

    // address match, shared by write decode and read selection
    function automatic logic spg_hit(
        input logic [DATA_W-1:0] instr,
        input logic [ADDR_W-1:0] addr
    );
        return instr[ADDR_W-1:0] == addr;
    endfunction

    // put a byte into or out of the wire order
    function automatic logic [DATA_W-1:0] spg_order(
        input logic              lsb,
        input logic [DATA_W-1:0] v
    );
        return lsb ? spg_rev8(v) : v;
    endfunction

    // ==================================================================
    // serial clock domain
    // ==================================================================
    assign at_instr_last = (cnt_q == CNT_INSTR_LAST);
    assign at_wr_last    = (cnt_q == CNT_WR_LAST);
    assign at_rd_first   = (cnt_q == CNT_RD_FIRST);
    assign out_win       = rd_go_q
                           && (cnt_q >= CNT_RD_FIRST)
                           && (cnt_q <= CNT_RD_LAST);
    assign out_idx       = 3'(CNT_RD_LAST - cnt_q);
    assign cnt_d         = (cnt_q == CNT_MAX) ? cnt_q
                                              : CNT_W'(cnt_q + 6'h01);

    // read flag position
    // the read flag is the first wire bit in one order and the last in
    // the other; the current input bit is the last one of the byte
    assign rw_raw        = lsb_s2_q ? i_spi_sdio : sh_q[6];

    // chip select high ends the frame and clears the bit count, read flag and output state; the
    // serial clock does not run then, so this reset cannot be clocked
    always_ff @(posedge i_spi_sclk or posedge i_spi_cs_b) begin
        if (i_spi_cs_b) begin
            cnt_q     <= '0;
            rd_go_q   <= 1'b0;
            out_q     <= 1'b0;
            sdio_oe_q <= 1'b0;
            sdo_oe_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            if (at_instr_last) begin
                rd_go_q <= rw_raw;
            end
            if (out_win) begin
                out_q <= rdata_q[out_idx];
            end
            if (rd_go_q && at_rd_first) begin
                sdio_oe_q <= dir_s2_q;
                sdo_oe_q  <= ~dir_s2_q;
            end
        end
    end

    // shift register and the words handed to the core side; they hold
    // still after the frame, which the core relies on when it takes them
    always_ff @(posedge i_spi_sclk) begin
        sh_q <= {sh_q[14:0], i_spi_sdio};
        if (cnt_q == '0) begin
            wr_ok_q <= 1'b0;
        end
        if (at_instr_last) begin
            instr_q <= {sh_q[6:0], i_spi_sdio};
        end
        if (at_wr_last) begin
            word_q  <= {sh_q[14:0], i_spi_sdio};
            wr_ok_q <= ~rd_go_q;
        end
    end

    // configuration levels into the serial domain; they settle within
    // the first two bits, long before either is looked at
    always_ff @(posedge i_spi_sclk) begin
        dir_s1_q <= dir_q;
        dir_s2_q <= dir_s1_q;
        lsb_s1_q <= lsb_q;
        lsb_s2_q <= lsb_s1_q;
    end

    assign o_spi_sdio                  = out_q;
    assign o_spi_sdio_oe               = sdio_oe_q;
    assign o_serial_data_output_pin    = out_q;
    assign o_serial_data_output_pin_oe = sdo_oe_q;

    // ==================================================================
    // core domain
    // ==================================================================
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            go_s1_q <= 1'b0;
            go_s2_q <= 1'b0;
            go_s3_q <= 1'b0;
        end else begin
            cs_s1_q <= i_spi_cs_b;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            go_s1_q <= rd_go_q;
            go_s2_q <= go_s1_q;
            go_s3_q <= go_s2_q;
        end
    end

    assign frame_end  = cs_s2_q & ~cs_s3_q;
    assign rd_start   = go_s2_q & ~go_s3_q;

    assign wr_instr   = spg_order(lsb_q, word_q[15:8]);
    assign wr_data    = spg_order(lsb_q, word_q[7:0]);
    assign rd_instr   = spg_order(lsb_q, instr_q);

    // commit at frame end
    // writes land only once the frame is over, so a new bit order or
    // pin choice never switches in the middle of an access
    assign wr_fire    = frame_end & wr_ok_q & ~wr_instr[BIT_RW];
    assign wr_general = wr_fire & spg_hit(wr_instr, ADDR_GENERAL);
    assign soft_rst   = wr_general & wr_data[BIT_SOFT_RESET];
    assign cfg_rst    = ~i_rst_b | soft_rst;

    always_ff @(posedge i_core_clk) begin
        if (cfg_rst) begin
            dir_q <= RST_GENERAL[BIT_SHARED_LINE];
            lsb_q <= RST_GENERAL[BIT_LSB_FIRST];
        end else if (wr_general) begin
            dir_q <= wr_data[BIT_SHARED_LINE];
            lsb_q <= wr_data[BIT_LSB_FIRST];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            relock_q <= 1'b0;
        end else begin
            relock_q <= soft_rst;
        end
    end

    // auxiliary registers; behaviour beyond storage lives elsewhere
    for (genvar g = 0; g < AUX_RW_N; g++) begin : g_aux
        wire aux_we = wr_fire & spg_hit(wr_instr, AUX_RW_ADDR[g]);

        always_ff @(posedge i_core_clk) begin
            if (cfg_rst) begin
                aux_q[g] <= RST_AUX;
            end else if (aux_we) begin
                aux_q[g] <= wr_data;
            end
        end

        assign o_aux_regs[g*8 +: 8] = aux_q[g];
    end

    // soft reset reads zero
    // the soft reset bit has no storage, so it can never read back set
    assign gen_val = {dir_q, lsb_q, 1'b0, 5'h00};

    always_comb begin
        aux_val = '0;
        for (int k = 0; k < AUX_RW_N; k++) begin
            if (spg_hit(rd_instr, AUX_RW_ADDR[k])) begin
                aux_val = aux_q[k];
            end
        end
    end

    assign rd_val =
        spg_hit(rd_instr, ADDR_GENERAL)   ? gen_val :
        spg_hit(rd_instr, ADDR_ADC_A1_LO) ? {i_aux_adc_a1[1:0], 6'h00} :
        spg_hit(rd_instr, ADDR_ADC_A1_HI) ? i_aux_adc_a1[9:2] :
        spg_hit(rd_instr, ADDR_ADC_B_LO)  ? {i_aux_adc_b[1:0], 6'h00} :
        spg_hit(rd_instr, ADDR_ADC_B_HI)  ? i_aux_adc_b[9:2] :
        aux_val;

    // read byte in wire order
    // stored already swapped so the serial side always walks it the
    // same way; it is held until the next read, which keeps it steady
    // for the whole data phase
    assign rdata_d = spg_order(lsb_q, rd_val);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            rdata_q <= '0;
        end else if (rd_start) begin
            rdata_q <= rdata_d;
        end
    end

    assign o_shared_data_line_select = dir_q;
    assign o_lsb_first               = lsb_q;
    assign o_pll_relock              = relock_q;

endmodule // spg_serial_port

`default_nettype wire

/* File: verif/spg_properties.sv */
// Purpose: assertions on the general configuration port
// Assumes: serial outputs are sampled on the core clock
// Notes:   bound into spg_serial_port
`timescale 1ns/1ns
`default_nettype none
module spg_properties (
    input wire logic        i_core_clk,
    input wire logic        i_rst_b,
    input wire logic        i_spi_cs_b,
    input wire logic        o_spi_sdio_oe,
    input wire logic        o_serial_data_output_pin_oe,
    input wire logic        o_shared_data_line_select,
    input wire logic        o_lsb_first,
    input wire logic        o_pll_relock,
    input wire logic [55:0] o_aux_regs
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    sequence s_one_pulse;
        o_pll_relock ##1 !o_pll_relock;
    endsequence
    sequence s_defaults;
        !o_shared_data_line_select && !o_lsb_first && o_aux_regs == '0;
    endsequence
    chk_relock_one_cycle: assert property (
        $rose(o_pll_relock) |-> s_one_pulse)
        else $error("relock pulse not one cycle");
    chk_soft_defaults: assert property (
        o_pll_relock |-> ##1 s_defaults)
        else $error("soft reset left a register set");
    chk_relock_after_write: assert property (
        o_pll_relock |-> i_spi_cs_b)
        else $error("relock inside a frame");
    chk_sep_pin_mode: assert property (
        o_serial_data_output_pin_oe |-> !o_shared_data_line_select)
        else $error("separate pin driven in shared mode");
    chk_shared_pin_mode: assert property (
        o_spi_sdio_oe |-> o_shared_data_line_select)
        else $error("shared pin driven in separate mode");
    chk_oe_in_frame: assert property (
        (o_spi_sdio_oe || o_serial_data_output_pin_oe) |-> !i_spi_cs_b)
        else $error("output enabled outside a frame");
    chk_order_at_rest: assert property (
        $changed(o_lsb_first) |-> i_spi_cs_b && $past(i_spi_cs_b))
        else $error("bit order changed inside a frame");
    chk_line_at_rest: assert property (
        $changed(o_shared_data_line_select)
            |-> i_spi_cs_b && $past(i_spi_cs_b))
        else $error("line select changed inside a frame");
endmodule // spg_properties
bind spg_serial_port spg_properties spg_properties_i (.i_core_clk, .i_rst_b,
    .i_spi_cs_b, .o_spi_sdio_oe, .o_serial_data_output_pin_oe,
    .o_shared_data_line_select, .o_lsb_first, .o_pll_relock, .o_aux_regs);
`default_nettype wire

/* File: verif/spg_host_model.sv */
// Purpose: host controller that runs serial frames
// Assumes: 6 ns serial clock, idle low between frames
// Notes:   released data lines toggle so stale values never match
`timescale 1ns/1ns
`default_nettype none
module spg_host_model (
    output var logic o_sclk,
    output var logic o_cs_b,
    output var logic o_sdio,
    input wire logic i_dev_sdio,
    input wire logic i_dev_sdio_oe,
    input wire logic i_dev_sep,
    input wire logic i_dev_sep_oe
);
    logic drv;
    logic seen_sh;
    // shared wire: device wins while its enable is up
    assign o_sdio = i_dev_sdio_oe ? i_dev_sdio : drv;
    initial begin
        o_sclk = 0;
        o_cs_b = 1;
        drv = 0;
        seen_sh = 0;
    end
    task automatic xfer(input logic rd, input logic [6:0] a,
        input logic [7:0] wd, input logic lsb, input logic sh,
        output logic [7:0] q);
        logic [7:0] b;
        logic s;
        q = '0;
        seen_sh = 0;
        o_cs_b = 0;
        #3;
        for (int k = 0; k < (rd ? 32 : 16); k++) begin
            b = (k < 8) ? {rd, a} : wd;
            drv = (rd && k >= 8) ? ~drv : (lsb ? b[k%8] : b[7-k%8]);
            #3;
            // an undriven separate pin reads inverted, so a missing
            // enable can never pass as good data
            s = sh ? o_sdio : (i_dev_sep_oe ? i_dev_sep : ~i_dev_sep);
            if (k >= 24) q = lsb ? {s, q[7:1]} : {q[6:0], s};
            seen_sh |= i_dev_sdio_oe;
            o_sclk = 1;
            #3;
            o_sclk = 0;
        end
        #3;
        o_cs_b = 1;
        #100;
    endtask
endmodule // spg_host_model
`default_nettype wire

/* File: verif/test_serial_port_general_config.sv */
// Purpose: self-checking bench for the general configuration port
// Assumes: host model paces frames and the gaps between them
// Notes:   random data from an xorshift seeded at 32'hB621
`timescale 1ns/1ns
`default_nettype none
module test_serial_port_general_config;
    import spg_pkg::*;
    logic i_core_clk, i_rst_b, sclk, cs_b, sdio;
    logic sdio_o, sdio_oe, sep_o, sep_oe, sh_sel, lsb_sel, relock;
    logic [ADC_W-1:0] a1, bv;
    logic [55:0] aux;
    logic [31:0] seed;
    logic [7:0] got;
    logic [7:0] mem [AUX_RW_N];
    int miscompares, checks, pulses;
    spg_serial_port spg_serial_port_i (.i_core_clk, .i_rst_b,
        .i_spi_sclk(sclk), .i_spi_cs_b(cs_b), .i_spi_sdio(sdio),
        .o_spi_sdio(sdio_o), .o_spi_sdio_oe(sdio_oe),
        .o_serial_data_output_pin(sep_o), .o_serial_data_output_pin_oe(sep_oe),
        .i_aux_adc_a1(a1), .i_aux_adc_b(bv),
        .o_shared_data_line_select(sh_sel), .o_lsb_first(lsb_sel),
        .o_pll_relock(relock), .o_aux_regs(aux));
    spg_host_model spg_host_model_i (.o_sclk(sclk), .o_cs_b(cs_b),
        .o_sdio(sdio), .i_dev_sdio(sdio_o), .i_dev_sdio_oe(sdio_oe),
        .i_dev_sep(sep_o), .i_dev_sep_oe(sep_oe));
    initial begin
        i_core_clk = 0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge i_core_clk) if (relock === 1'b1) pulses++;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [7:0] exp_adc(input logic [6:0] a,
        input logic [9:0] x, input logic [9:0] y);
        logic [9:0] v;
        v = a[1] ? y : x;
        return a[0] ? v[9:2] : {v[1:0], 6'h00};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    task automatic rw(input logic rd, input logic [6:0] a, input logic [7:0] wd,
        input logic lsb, input logic sh);
        spg_host_model_i.xfer(rd, a, wd, lsb, sh, got);
    endtask
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        seed = 32'hB621;
        {miscompares, checks, pulses} = '0;
        i_rst_b = 0;
        a1 = '0;
        bv = '0;
        repeat (8) @(posedge i_core_clk);
        @(negedge i_core_clk) i_rst_b = 1;
        repeat (4) @(negedge i_core_clk);
        rw(1, ADDR_GENERAL, 0, 0, 0);
        chk("general", 8'h00, got);
        $display("test defaults done");
        for (int g = 0; g < AUX_RW_N; g++) begin
            seed = xs(seed);
            mem[g] = seed[7:0];
            rw(0, AUX_RW_ADDR[g], mem[g], 0, 0);
        end
        for (int g = 0; g < AUX_RW_N; g++) begin
            rw(1, AUX_RW_ADDR[g], 0, 0, 0);
            chk("aux read", mem[g], got);
            chk("aux port", mem[g], aux[g*8+:8]);
        end
        rw(1, 7'h10, 0, 0, 0);
        chk("unmapped", 8'h00, got);
        $display("test aux done");
        seed = xs(seed);
        @(negedge i_core_clk) {a1, bv} = {seed[9:0], seed[25:16]};
        rw(0, ADDR_ADC_A1_HI, 8'hFF, 0, 0);
        for (int r = 0; r < 4; r++) begin
            rw(1, ADDR_ADC_A1_LO + r[6:0], 0, 0, 0);
            chk("adc", exp_adc(ADDR_ADC_A1_LO + r[6:0], a1, bv), got);
        end
        $display("test adc done");
        rw(0, ADDR_GENERAL, 8'h40, 0, 0);
        chk("lsb port", 8'h01, {7'h00, lsb_sel});
        rw(1, ADDR_GENERAL, 0, 1, 0);
        chk("general lsb", 8'h40, got);
        rw(0, AUX_RW_ADDR[0], 8'h1C, 1, 0);
        chk("aux lsb", 8'h1C, aux[7:0]);
        $display("test lsb done");
        rw(0, ADDR_GENERAL, 8'hC0, 1, 0);
        rw(1, ADDR_GENERAL, 0, 1, 1);
        chk("general shared", 8'hC0, got);
        chk("shared oe", 8'h01, {7'h00, spg_host_model_i.seen_sh});
        $display("test shared done");
        pulses = 0;
        rw(0, ADDR_GENERAL, 8'hE0, 1, 1);
        chk("relock", 8'h01, pulses[7:0]);
        chk("cfg", 8'h00, {6'h00, sh_sel, lsb_sel});
        chk("aux cleared", 8'h00, aux[7:0]);
        rw(1, ADDR_GENERAL, 0, 0, 0);
        chk("after soft", 8'h00, got);
        $display("test soft reset done");
        print_verdict();
    end
endmodule // test_serial_port_general_config
`default_nettype wire
